//--- rtl/ptc_pkg.sv
// constants shared by the preset timer/counter design
package ptc_pkg;
  // ----------------------------------------------------------------
  // dataway function and subaddress codes
  // ----------------------------------------------------------------
  localparam logic [4:0] FN_READ     = 5'h00;
  localparam logic [4:0] FN_TEST_L   = 5'h08;
  localparam logic [4:0] FN_TCLR_L   = 5'h0a;
  localparam logic [4:0] FN_WRITE    = 5'h10;
  localparam logic [4:0] FN_DIS_L    = 5'h18;
  localparam logic [4:0] FN_EN_L     = 5'h1a;
  localparam logic [4:0] FN_TEST_BSY = 5'h1b;
  localparam logic [4:0] FN_START    = 5'h1c;
  localparam logic [3:0] SA_COUNTER  = 4'h0;
  localparam logic [3:0] SA_DIVIDER  = 4'h1;
  localparam logic [3:0] SA_DISABLE  = 4'h1;
  // ----------------------------------------------------------------
  // register layout and reset values
  // ----------------------------------------------------------------
  localparam int          CNT_W       = 16;
  localparam int          SEL_W       = 7;
  localparam int          DIV_W       = 18;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [6:0]  SEL_RST     = 7'h00;
  // step-down exponent of each control bit, bit 0 first
  localparam logic [4:0]  EXP_B0      = 5'h00;
  localparam logic [4:0]  EXP_B1      = 5'h03;
  localparam logic [4:0]  EXP_B2      = 5'h06;
  localparam logic [4:0]  EXP_B3      = 5'h09;
  localparam logic [4:0]  EXP_B4      = 5'h0c;
  localparam logic [4:0]  EXP_B5      = 5'h0f;
  localparam logic [4:0]  EXP_B6      = 5'h12;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int          CLK_HZ      = 125000000;
  localparam int          OSC_HZ      = 262144;
  localparam int          OSC_HALF    = CLK_HZ / (2 * OSC_HZ);
  localparam int          OSC_W       = 9;
endpackage : ptc_pkg

//--- rtl/ptc_sync.sv
// two-stage synchroniser with rising-edge pulse for pin inputs
module ptc_sync #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_nrst,
  // asynchronous pins
  input  wire logic [WIDTH-1:0] i_pin,
  // synchronised level and rising edge
  output logic      [WIDTH-1:0] o_lvl,
  output logic      [WIDTH-1:0] o_rise
);
  import ptc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] lvl;
    logic [WIDTH-1:0] old;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // ------------------------------------------------------------
  // next state: meta feeds only the second stage
  // ------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = i_pin;
    st_nxt.lvl  = st_r.meta;
    st_nxt.old  = st_r.lvl;
  end

  // registers
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // level and edge come from the second and third stages only
  assign o_lvl  = st_r.lvl;
  assign o_rise = st_r.lvl & ~st_r.old;
endmodule : ptc_sync

//--- rtl/ptc_divider.sv
// power-of-two step-down divider in front of the preset counter
module ptc_divider (
  // clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_nrst,
  // control
  input  wire logic                    i_clr,
  input  wire logic [ptc_pkg::SEL_W-1:0] i_sel,
  // input pulse and divided tick
  input  wire logic                    i_pulse,
  output logic                         o_tick
);
  import ptc_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } div_t;

  div_t st_r;
  div_t st_nxt;

  // exponent of the selected ratio; a zero selection inhibits
  function automatic logic [4:0] sel_exp(input logic [SEL_W-1:0] s);
    logic [4:0] e;
    e = EXP_B0;
    if (s[1]) e = EXP_B1;
    if (s[2]) e = EXP_B2;
    if (s[3]) e = EXP_B3;
    if (s[4]) e = EXP_B4;
    if (s[5]) e = EXP_B5;
    if (s[6]) e = EXP_B6;
    return e;
  endfunction : sel_exp

  logic [DIV_W:0] last;

  // ------------------------------------------------------------
  // divider step
  // ------------------------------------------------------------
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    last        = (DIV_W + 1)'(1) << sel_exp(i_sel);
    if (i_clr) begin
      st_nxt.cnt = '0;
    end else if (i_pulse && (i_sel != '0)) begin
      if ((DIV_W + 1)'(st_r.cnt) + (DIV_W + 1)'(1) >= last) begin
        st_nxt.cnt  = '0;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_tick = st_r.tick;
endmodule : ptc_divider

//--- rtl/ptc_top.sv
// preset timer/counter behind a dataway crate controller
module ptc_top #(
  parameter int OSC_HALF_CYC = ptc_pkg::OSC_HALF
) (
  // clock and reset
  input  wire logic                      i_mclk,
  input  wire logic                      i_nrst,
  // dataway
  input  wire logic                      i_n,
  input  wire logic                      i_s1,
  input  wire logic                      i_s2,
  input  wire logic                      i_z,
  input  wire logic [4:0]                i_f,
  input  wire logic [3:0]                i_a,
  input  wire logic [ptc_pkg::CNT_W-1:0] i_w,
  output logic      [ptc_pkg::CNT_W-1:0] o_r,
  output logic                           o_q,
  output logic                           o_l,
  // front panel inputs
  input  wire logic                      i_in_a,
  input  wire logic                      i_in_b,
  input  wire logic                      i_start,
  input  wire logic                      i_restart,
  input  wire logic                      i_stop,
  // front panel outputs
  output logic                           o_busy,
  output logic                           o_end,
  output logic                           o_preset_out,
  output logic                           o_oscillator_output
);
  import ptc_pkg::*;

  localparam int SW = 9 + 5 + 4 + CNT_W;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             done;
    logic             l_en;
    logic [SEL_W-1:0] sel;
    logic             frz;
    logic             pend;
    logic [CNT_W-1:0] rd;
    logic             q;
    logic             endp;
    logic             presetp;
    logic [OSC_W-1:0] osc_cnt;
    logic             osc;
    logic             in_old;
  } top_t;

  top_t st_r;
  top_t st_nxt;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [SW-1:0] pin_lvl;
  logic [SW-1:0] pin_rise;

  ptc_sync #(
    .WIDTH (SW)
  ) u_sync (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_pin  ({i_w, i_a, i_f, i_in_b, i_in_a, i_stop, i_restart, i_start,
              i_z, i_s2, i_s1, i_n}),
    .o_lvl  (pin_lvl),
    .o_rise (pin_rise)
  );

  logic             n_lvl;
  logic             s1_rise;
  logic             s2_rise;
  logic             z_lvl;
  logic             start_p;
  logic             restart_p;
  logic             stop_p;
  logic             ina_lvl;
  logic             inb_lvl;
  logic [4:0]       fn;
  logic [3:0]       sa;
  logic [CNT_W-1:0] wd;

  assign n_lvl     = pin_lvl[0];
  assign s1_rise   = pin_rise[1];
  assign s2_rise   = pin_rise[2];
  assign z_lvl     = pin_lvl[3];
  assign start_p   = pin_rise[4];
  assign restart_p = pin_rise[5];
  assign stop_p    = pin_rise[6];
  assign ina_lvl   = pin_lvl[7];
  assign inb_lvl   = pin_lvl[8];
  assign fn        = pin_lvl[13:9];
  assign sa        = pin_lvl[17:14];
  assign wd        = pin_lvl[SW-1:18];

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  function automatic logic is_cmd(input logic [4:0] f, input logic [3:0] a,
                                  input logic [4:0] fc, input logic [3:0] ac);
    return (f == fc) && (a == ac);
  endfunction : is_cmd

  logic cmd;
  logic init;
  logic c_read;
  logic c_load;
  logic c_div;
  logic c_start;

  // commands act once, on the first strobe of an addressed cycle
  assign cmd     = n_lvl & s1_rise;
  // initialize is qualified by the second strobe of its cycle
  assign init    = z_lvl & s2_rise;
  assign c_read  = is_cmd(fn, sa, FN_READ, SA_COUNTER);
  assign c_load  = is_cmd(fn, sa, FN_WRITE, SA_COUNTER);
  assign c_div   = is_cmd(fn, sa, FN_WRITE, SA_DIVIDER);
  assign c_start = is_cmd(fn, sa, FN_START, SA_COUNTER);

  // ------------------------------------------------------------
  // count path: AND gate, busy gate, divider
  // ------------------------------------------------------------
  logic in_and;
  logic tick;
  logic div_clr;

  assign in_and  = ina_lvl & inb_lvl;
  assign div_clr = init | (cmd & c_div);

  ptc_divider u_div (
    .i_mclk  (i_mclk),
    .i_nrst  (i_nrst),
    .i_clr   (div_clr),
    .i_sel   (st_r.sel),
    .i_pulse (in_and & ~st_r.in_old & st_r.busy),
    .o_tick  (tick)
  );

  // ------------------------------------------------------------
  // flags, counter and dataway answers
  // ------------------------------------------------------------
  logic inc;
  logic term;
  logic clr_cnt;
  logic lreq;

  assign lreq = st_r.done & st_r.l_en;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.endp    = 1'b0;
    st_nxt.presetp = 1'b0;
    inc            = 1'b0;
    term           = 1'b0;
    clr_cnt        = 1'b0;
    // edge of the gated input; long gate levels give one count
    st_nxt.in_old  = in_and;
    // a pulse arriving while frozen is held, one at most
    if (tick && st_r.busy && st_r.frz) begin
      st_nxt.pend = 1'b1;
    end
    if (tick && st_r.busy && !st_r.frz) begin
      inc = 1'b1;
    end
    // freeze opens with an addressed read, closes at the second strobe
    if (n_lvl && c_read && !st_r.frz && !st_r.q) begin
      st_nxt.frz = 1'b1;
    end
    if (s2_rise && st_r.frz) begin
      st_nxt.frz  = 1'b0;
      st_nxt.pend = 1'b0;
      inc         = st_r.pend | (tick & st_r.busy);
    end
    if (inc) begin
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
      term       = (st_r.cnt == '1);
    end
    if (term) begin
      st_nxt.busy = 1'b0;
    end
    // panel commands; start wins over a same-cycle stop
    if (stop_p) begin
      st_nxt.busy = 1'b0;
    end
    if (start_p) begin
      st_nxt.busy = 1'b1;
    end
    if (restart_p) begin
      st_nxt.busy = 1'b1;
      clr_cnt     = 1'b1;
    end
    // answers fall when the station is released
    if (!n_lvl) begin
      st_nxt.q  = 1'b0;
      st_nxt.rd = '0;
    end
    if (cmd) begin
      unique case (fn)
        FN_READ: begin
          st_nxt.rd = st_r.cnt;
          st_nxt.q  = c_read;
        end
        FN_WRITE: begin
          if (c_load) begin
            st_nxt.cnt     = ~wd;
            st_nxt.presetp = 1'b1;
            st_nxt.done    = 1'b0;
            st_nxt.q       = 1'b1;
          end else if (c_div) begin
            st_nxt.sel = wd[SEL_W-1:0];
            st_nxt.q   = 1'b1;
          end
        end
        FN_START: begin
          if (c_start) begin
            clr_cnt     = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.done = 1'b0;
          end
        end
        FN_TEST_BSY: st_nxt.q = (sa == SA_COUNTER) && st_r.busy;
        FN_TEST_L:   st_nxt.q = (sa == SA_COUNTER) && lreq;
        FN_TCLR_L: begin
          if (sa == SA_COUNTER) begin
            st_nxt.q    = lreq;
            st_nxt.done = 1'b0;
          end
        end
        FN_EN_L:  st_nxt.l_en = (sa == SA_COUNTER) ? 1'b1 : st_r.l_en;
        FN_DIS_L: st_nxt.l_en = (sa == SA_DISABLE) ? 1'b0 : st_r.l_en;
        default: ;
      endcase
    end
    if (clr_cnt) begin
      st_nxt.cnt = '0;
    end
    // completion sets done even against a same-cycle clear
    if (term) begin
      st_nxt.done = 1'b1;
    end
    if (init) begin
      st_nxt.busy = 1'b0;
      st_nxt.done = 1'b0;
      st_nxt.cnt  = CNT_RST;
      st_nxt.sel  = SEL_RST;
      st_nxt.l_en = 1'b0;
      st_nxt.frz  = 1'b0;
      st_nxt.pend = 1'b0;
    end
    // end pulse on every transition into a clear counter
    st_nxt.endp = (st_nxt.cnt == '0) && ((st_r.cnt != '0) || term || clr_cnt);
    // free-running square wave for the panel oscillator output
    if (st_r.osc_cnt >= OSC_W'(OSC_HALF_CYC - 1)) begin
      st_nxt.osc_cnt = '0;
      st_nxt.osc     = ~st_r.osc;
    end else begin
      st_nxt.osc_cnt = st_r.osc_cnt + OSC_W'(1);
    end
  end

  // registers
  always_ff @(posedge i_mclk) begin
    if (!i_nrst) begin
      st_r     <= '0;
      st_r.cnt <= CNT_RST;
      st_r.sel <= SEL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign o_r                 = st_r.rd;
  assign o_q                 = st_r.q;
  assign o_l                 = lreq;
  assign o_busy              = st_r.busy;
  assign o_end               = st_r.endp;
  assign o_preset_out        = st_r.presetp;
  assign o_oscillator_output = st_r.osc;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);

  AST_LOAD_COMP: assert property (cmd && c_load && !init |=>
    st_r.cnt == ~$past(wd) && o_preset_out && !st_r.done && o_q)
    else $error("load did not store the complement");
  AST_END_ON_CLEAR: assert property ($changed(st_r.cnt) && st_r.cnt == '0 |->
    o_end) else $error("no end pulse on clear counter");
  AST_DIV_WRITE: assert property (cmd && c_div && !init |=>
    st_r.sel == $past(wd[SEL_W-1:0]) && o_q)
    else $error("divider selection not stored");
  AST_INHIBIT: assert property (st_r.sel == '0 && !div_clr |=> !tick)
    else $error("divider ticked while inhibited");
  AST_START_FN: assert property (cmd && c_start && !init |=>
    st_r.busy && !st_r.done && st_r.cnt == '0)
    else $error("start function misbehaved");
  AST_BUSY_TEST: assert property (cmd && fn == FN_TEST_BSY && sa == SA_COUNTER |=>
    o_q == $past(st_r.busy)) else $error("busy test answer wrong");
  AST_TCLR: assert property (cmd && is_cmd(fn, sa, FN_TCLR_L, SA_COUNTER) && !term |=>
    o_q == $past(lreq) && !st_r.done) else $error("test and clear wrong");
  AST_INIT: assert property (init |=>
    !o_busy && !st_r.done && st_r.cnt == '0 && !st_r.l_en && st_r.sel == '0)
    else $error("initialize left state behind");
  AST_FREEZE: assert property (st_r.frz && !s2_rise && !init |=>
    st_r.cnt == $past(st_r.cnt) || $past(clr_cnt) || $past(cmd))
    else $error("counter moved while frozen");
  AST_STOP: assert property (stop_p && !start_p && !restart_p && !(cmd && c_start) |=>
    !o_busy) else $error("stop did not clear busy");
  AST_TERM: assert property (term && !init |=> st_r.done && (!o_busy || $past(start_p)
    || $past(restart_p) || $past(cmd))) else $error("completion flags wrong");
  AST_GATE: assert property (!st_r.busy && !st_r.frz |=>
    st_r.cnt == $past(st_r.cnt) || $past(clr_cnt) || $past(cmd) || $past(init))
    else $error("counted while idle");

  COV_COMPLETE: cover property (term ##1 o_l);
  COV_HELD_PULSE: cover property (st_r.frz && st_r.pend ##1 s2_rise);
  COV_RESTART: cover property (restart_p ##1 o_end);
endmodule : ptc_top

//--- testbench/dataway_ctrl.sv
// crate controller model that runs one dataway cycle at a time
module dataway_ctrl (
  // clock
  input  wire logic        i_mclk,
  // dataway toward the station
  output logic             o_n,
  output logic             o_s1,
  output logic             o_s2,
  output logic             o_z,
  output logic [4:0]       o_f,
  output logic [3:0]       o_a,
  output logic [15:0]      o_w,
  // answer from the station
  input  wire logic [15:0] i_r,
  input  wire logic        i_q
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero, write lines parked on a pattern
  initial begin
    o_n  = 1'b0;
    o_s1 = 1'b0;
    o_s2 = 1'b0;
    o_z  = 1'b0;
    o_f  = 5'h00;
    o_a  = 4'h0;
    o_w  = 16'h5a5a;
  end

  // wait whole clocks, then step just past the edge
  task automatic wt(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask : wt

  // ----------------------------------------------------------------
  // one full N / S1 / S2 cycle; z set makes it an initialize cycle
  // ----------------------------------------------------------------
  task automatic cycle(input logic [4:0] f, input logic [3:0] a, input logic [15:0] w,
                       input logic z, output logic [15:0] r, output logic q);
    o_n = ~z;
    o_z = z;
    o_f = f;
    o_a = a;
    o_w = w;
    wt(4);
    o_s1 = 1'b1;
    // strobes held well past the two-stage sync so the answer has landed
    wt(6);
    r = i_r;
    q = i_q;
    o_s1 = 1'b0;
    wt(4);
    o_s2 = 1'b1;
    wt(5);
    o_s2 = 1'b0;
    wt(4);
    o_n = 1'b0;
    o_z = 1'b0;
    // released write bus shows no stale word
    o_w = ~w;
    wt(6);
  endtask : cycle
endmodule : dataway_ctrl

//--- testbench/preset_timer_counter_tb.sv
// self-checking bench for the preset timer/counter
module preset_timer_counter_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ptc_pkg::*;

  logic        mclk, nrst, n, s1, s2, z, q, l;
  logic        in_a, in_b, start, restart, stop, busy, endp, pre;
  logic        osc, osc_q;
  logic [4:0]  f;
  logic [3:0]  a;
  logic [15:0] w, r, rd;
  logic        qa;
  int          errors = 0;
  int          total_checks = 0;
  int          ends = 0;
  int          presets = 0;
  int          e0;
  int          flips = 0;

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  dataway_ctrl ctl (.i_mclk(mclk), .o_n(n), .o_s1(s1), .o_s2(s2), .o_z(z), .o_f(f),
                    .o_a(a), .o_w(w), .i_r(r), .i_q(q));

  // short oscillator half period keeps that output busy in sim
  ptc_top #(.OSC_HALF_CYC(2)) uut (.i_mclk(mclk), .i_nrst(nrst), .i_n(n), .i_s1(s1),
    .i_s2(s2), .i_z(z), .i_f(f), .i_a(a), .i_w(w), .o_r(r), .o_q(q), .o_l(l),
    .i_in_a(in_a), .i_in_b(in_b), .i_start(start), .i_restart(restart), .i_stop(stop),
    .o_busy(busy), .o_end(endp), .o_preset_out(pre), .o_oscillator_output(osc));

  // one-cycle panel pulses are tallied, not sampled by chance
  always_ff @(posedge mclk) begin
    if (endp === 1'b1) ends <= ends + 1;
    if (pre === 1'b1) presets <= presets + 1;
    osc_q <= osc;
    if (osc !== osc_q) flips <= flips + 1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_flag(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_flag

  task automatic clk_n(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : clk_n

  task automatic cmd(input logic [4:0] fc, input logic [3:0] sa, input logic [15:0] wd);
    ctl.cycle(fc, sa, wd, 1'b0, rd, qa);
  endtask : cmd

  // panel pulse: 0 start, 1 restart, else stop
  task automatic pin(input int k);
    case (k)
      0: start = 1'b1;
      1: restart = 1'b1;
      default: stop = 1'b1;
    endcase
    clk_n(3);
    start = 1'b0;
    restart = 1'b0;
    stop = 1'b0;
    clk_n(5);
  endtask : pin

  task automatic edges(input int k);
    repeat (k) begin
      in_a = 1'b1;
      clk_n(2);
      in_a = 1'b0;
      clk_n(2);
    end
    clk_n(4);
  endtask : edges

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  // hang guard
  initial begin
    #(20000 * 8);
    errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    in_a = 1'b0;
    in_b = 1'b1;
    start = 1'b0;
    restart = 1'b0;
    stop = 1'b0;
    clk_n(10);
    nrst = 1'b1;
    clk_n(4);
    // oscillator half period of two clocks gives twenty flips in forty
    e0 = flips;
    clk_n(40);
    chk_word(16'(flips - e0), 16'h0014); // oscillator output
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'h0000);
    chk_flag(qa, 1'b1);
    // load keeps the complement and fires the preset strobe
    cmd(FN_WRITE, SA_COUNTER, 16'h0003);
    chk_flag(qa, 1'b1);
    chk_word(16'(presets), 16'h0001);
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'hfffc);
    // zero selection lets nothing through
    cmd(FN_WRITE, SA_DIVIDER, 16'h0000);
    pin(0);
    chk_flag(busy, 1'b1);
    edges(4);
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'hfffc);
    cmd(FN_TEST_BSY, SA_COUNTER, 16'h0000);
    chk_flag(qa, 1'b1);
    // ratio one: loaded count runs out
    cmd(FN_WRITE, SA_DIVIDER, 16'h0001);
    chk_flag(qa, 1'b1);
    // complement of three is all ones after three ticks, clear on the fourth
    edges(4);
    chk_word(16'(ends), 16'h0001);
    chk_flag(busy, 1'b0);
    chk_flag(l, 1'b0);
    cmd(FN_TEST_L, SA_COUNTER, 16'h0000);
    chk_flag(qa, 1'b0);
    cmd(FN_TEST_BSY, SA_COUNTER, 16'h0000);
    chk_flag(qa, 1'b0);
    cmd(FN_EN_L, SA_COUNTER, 16'h0000);
    chk_flag(l, 1'b1);
    cmd(FN_DIS_L, SA_DISABLE, 16'h0000);
    chk_flag(l, 1'b0);
    cmd(FN_EN_L, SA_COUNTER, 16'h0000);
    cmd(FN_TEST_L, SA_COUNTER, 16'h0000);
    chk_flag(qa, 1'b1);
    cmd(FN_TCLR_L, SA_COUNTER, 16'h0000);
    chk_flag(qa, 1'b1);
    chk_flag(l, 1'b0);
    cmd(FN_TEST_L, SA_COUNTER, 16'h0000);
    chk_flag(qa, 1'b0);
    // ratio eight from the start function, gating, stop
    cmd(FN_WRITE, SA_DIVIDER, 16'h0002);
    cmd(FN_START, SA_COUNTER, 16'h0000);
    chk_flag(busy, 1'b1);
    edges(16);
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'h0002);
    in_b = 1'b0;
    edges(8);
    in_b = 1'b1;
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'h0002);
    pin(2);
    chk_flag(busy, 1'b0);
    edges(8);
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'h0002);
    // restart, then a count edge lands inside a read
    cmd(FN_WRITE, SA_DIVIDER, 16'h0001);
    e0 = ends;
    pin(1);
    chk_flag(busy, 1'b1);
    chk_word(16'(ends - e0), 16'h0001);
    fork
      cmd(FN_READ, SA_COUNTER, 16'h0000);
      begin
        clk_n(5);
        in_a = 1'b1;
        clk_n(2);
        in_a = 1'b0;
      end
    join
    chk_word(rd, 16'h0000);
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'h0001);
    // initialize drops everything mid-run
    ctl.cycle(5'h00, 4'h0, 16'h0000, 1'b1, rd, qa);
    chk_flag(busy, 1'b0);
    pin(0);
    edges(2);
    cmd(FN_READ, SA_COUNTER, 16'h0000);
    chk_word(rd, 16'h0000);
    end_of_test();
  end
endmodule : preset_timer_counter_tb
